// *** dxs_params.svh ***
// constants for the drive exception status byte block
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef DXS_PARAMS_SVH
`define DXS_PARAMS_SVH
`define DXS_OFF_WRFLT     8'h00
`define DXS_OFF_DIAG      8'h04
`define DXS_OFF_HEAD      8'h08
`define DXS_OFF_OVR       8'h0c
`define DXS_OFF_CTRL      8'h10
`define DXS_OFF_SUMM      8'h14
`define DXS_B4_STROBE     3
`define DXS_B4_OFFSET     4
`define DXS_B4_NODATA     5
`define DXS_B4_WPROT      7
`define DXS_B5_DIAGDIS    5
`define DXS_B5_INCOMP     6
`define DXS_B5_DVALID     7
`define DXS_B7_FIELD      1
`define DXS_B7_SECTOR     2
`define DXS_B7_TRACK      3
`define DXS_B7_OPFLT      4
`define DXS_B7_LATE       5
`define DXS_B7_REJ_LO     6
`define DXS_B4_USED       8'hb8
`define DXS_B5_USED       8'he0
`define DXS_B7_USED       8'hfe
`define DXS_BYTE_RST      8'h00
`define DXS_DATA_WAIT_NS  1000
`define DXS_CLK_NS        8
`define DXS_DATA_WAIT_CYC ((`DXS_DATA_WAIT_NS + `DXS_CLK_NS - 1) / `DXS_CLK_NS)
`endif

// *** dxs_pkg.sv ***
// types for the drive exception status byte block
// assumes dxs_params.svh holds all numbers but these enum encodings
package dxs_pkg;
  typedef enum logic [1:0] {
    DXS_REJ_NONE     = 2'b00,
    DXS_REJ_INVALID  = 2'b01,
    DXS_REJ_CONFLICT = 2'b10,
    DXS_REJ_NORPS    = 2'b11
  } dxs_rej_t;
  typedef enum logic [1:0] {
    DXS_W_IDLE = 2'b00,
    DXS_W_WAIT = 2'b01,
    DXS_W_DATA = 2'b10
  } dxs_wst_t;
endpackage : dxs_pkg

// *** dxs_top.sv ***
// drive exception status bytes 4..7 with a wishbone register slave
// assumes drive event inputs are clk-domain pulses, status pins are async
//
// Summary of operation
// - write command with strobe active: strobe fault
// - write command with heads offset: offset fault
// - write accepted, no data arrives: transmission fault
// - write command while write protected: fault
// - byte5 bit5 shows diagnostics disabled
// - diagnostic could not complete: incomplete bit
// - diagnostic error seen: status valid bit
// - heads 0..6 each own error bit
// - byte6 msb: head 7 or 8 error
// - field end passed early: field overrun
// - sector boundary passed early: sector overrun
// - track end passed early: track overrun
// - any operation error: operation fault bit
// - data command arriving late: late bit
// - reject code 00 normal, 01 invalid
// - reject code 10 on operation conflict
// - reject code 11 when sensing disabled
// - unused positions carry no status meaning
// - read fault summary on read/verify error
`timescale 1ns/1ps
`include "dxs_params.svh"
module dxs_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        wr_cmd,
  input  wire logic        rd_cmd,
  input  wire logic        rd_op,
  input  wire logic        wr_data_seen,
  input  wire logic        cmd_invalid,
  input  wire logic        cmd_conflict,
  input  wire logic        cmd_late,
  input  wire logic        diag_incomplete,
  input  wire logic        diag_error,
  input  wire logic        field_pass,
  input  wire logic        sector_pass,
  input  wire logic        track_pass,
  input  wire logic        op_busy,
  input  wire logic [8:0]  head_fail,
  input  wire logic        strobe_early_pin,
  input  wire logic        strobe_late_pin,
  input  wire logic        head_offset_pin,
  input  wire logic        wprot_pin,
  input  wire logic        status_xfer,
  output logic             read_fault
);
  // async pin levels, two-stage
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else if (clk_en) begin
      pin_s1_q <= {wprot_pin, head_offset_pin, strobe_late_pin,
                   strobe_early_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic strobe_on;
  logic offset_on;
  logic wprot_on;
  assign strobe_on = pin_s2_q[0] | pin_s2_q[1];
  assign offset_on = pin_s2_q[2];
  assign wprot_on  = pin_s2_q[3];

  // software control: bit0 diag disable, bit1 rps enable, bit2 clear
  logic diag_dis_q;
  logic rps_en_q;
  logic wb_hit;
  logic wb_wr;
  logic sw_clear;
  assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land on the ack edge, while the master still holds the request
  assign wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign sw_clear = wb_wr & (wb_adr_i == `DXS_OFF_CTRL) & wb_dat_i[2];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      diag_dis_q <= 1'b0;
      rps_en_q   <= 1'b1;
    end else if (clk_en && wb_wr && wb_adr_i == `DXS_OFF_CTRL) begin
      diag_dis_q <= wb_dat_i[0];
      rps_en_q   <= wb_dat_i[1];
    end
  end
  // transfer of status to controller or software clear empties the bytes, all but the byte5 diag disable bit
  logic clr;
  assign clr = status_xfer | sw_clear;

  // write data watchdog
  dxs_pkg::dxs_wst_t wst_q;
  logic [7:0]        wcnt_q;
  logic              nodata_ev;
  assign nodata_ev = (wst_q == dxs_pkg::DXS_W_WAIT) & ~wr_data_seen &
                     (wcnt_q == 8'(`DXS_DATA_WAIT_CYC - 1));
  logic wr_ok;
  assign wr_ok = wr_cmd & ~cmd_invalid & ~cmd_conflict & rps_en_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wst_q  <= dxs_pkg::DXS_W_IDLE;
      wcnt_q <= 8'h00;
    end else if (clk_en) begin
      case (wst_q)
        dxs_pkg::DXS_W_IDLE: begin
          wcnt_q <= 8'h00;
          if (wr_ok)
            wst_q <= dxs_pkg::DXS_W_WAIT;
        end
        dxs_pkg::DXS_W_WAIT: begin
          wcnt_q <= wcnt_q + 8'h01;
          if (wr_data_seen)
            wst_q <= dxs_pkg::DXS_W_DATA;
          else if (nodata_ev)
            wst_q <= dxs_pkg::DXS_W_IDLE;
        end
        dxs_pkg::DXS_W_DATA: begin
          if (!op_busy)
            wst_q <= dxs_pkg::DXS_W_IDLE;
        end
        default: wst_q <= dxs_pkg::DXS_W_IDLE;
      endcase
    end
  end

  // new events, set beats clear
  logic       any_cmd;
  logic [7:0] b4_set;
  logic [7:0] b5_set;
  logic [7:0] b6_set;
  logic [7:0] b7_set;
  logic       op_err;
  assign any_cmd = wr_cmd | rd_cmd;
  always_comb begin
    b4_set = 8'h00;
    b5_set = 8'h00;
    b7_set = 8'h00;
    b4_set[`DXS_B4_STROBE] = wr_cmd & strobe_on;
    b4_set[`DXS_B4_OFFSET] = wr_cmd & offset_on;
    b4_set[`DXS_B4_NODATA] = nodata_ev;
    b4_set[`DXS_B4_WPROT]  = wr_cmd & wprot_on;
    b5_set[`DXS_B5_INCOMP] = diag_incomplete;
    b5_set[`DXS_B5_DVALID] = diag_error;
    b7_set[`DXS_B7_FIELD]  = field_pass & op_busy;
    b7_set[`DXS_B7_SECTOR] = sector_pass & op_busy;
    b7_set[`DXS_B7_TRACK]  = track_pass & op_busy;
    b7_set[`DXS_B7_LATE]   = any_cmd & cmd_late;
  end
  // head bits, 7 and 8 share msb
  assign b6_set = {head_fail[7] | head_fail[8], head_fail[6:0]};
  // reject code, priority no-rps > conflict > bad
  dxs_pkg::dxs_rej_t rej_d;
  logic              rej_ev;
  always_comb begin
    rej_d = dxs_pkg::DXS_REJ_NONE;
    if (any_cmd && !rps_en_q)
      rej_d = dxs_pkg::DXS_REJ_NORPS;
    else if (any_cmd && cmd_conflict)
      rej_d = dxs_pkg::DXS_REJ_CONFLICT;
    else if (any_cmd && cmd_invalid)
      rej_d = dxs_pkg::DXS_REJ_INVALID;
  end
  assign rej_ev = (rej_d != dxs_pkg::DXS_REJ_NONE);
  assign op_err = (|b4_set) | (|b7_set) | (|b6_set) | rej_ev;

  logic [7:0]        b4_q;
  logic [7:0]        b5_q;
  logic [7:0]        b6_q;
  logic [5:0]        b7_q;
  dxs_pkg::dxs_rej_t rej_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b4_q  <= `DXS_BYTE_RST;
      b5_q  <= `DXS_BYTE_RST;
      b6_q  <= `DXS_BYTE_RST;
      b7_q  <= 6'h00;
      rej_q <= dxs_pkg::DXS_REJ_NONE;
    end else if (clk_en) begin
      b4_q <= (clr ? 8'h00 : b4_q) | b4_set;
      b5_q <= (clr ? 8'h00 : b5_q) | b5_set;
      b6_q <= (clr ? 8'h00 : b6_q) | b6_set;
      b7_q <= (clr ? 6'h00 : b7_q) | b7_set[5:0];
      b7_q[`DXS_B7_OPFLT] <= (~clr & b7_q[`DXS_B7_OPFLT]) | op_err;
      // first reject since transfer is kept
      if (rej_ev && (clr || rej_q == dxs_pkg::DXS_REJ_NONE))
        rej_q <= rej_d;
      else if (clr)
        rej_q <= dxs_pkg::DXS_REJ_NONE;
    end
  end

  // assembled bytes, unused bits forced zero
  logic [7:0] byte4;
  logic [7:0] byte5;
  logic [7:0] byte7;
  assign byte4 = b4_q & `DXS_B4_USED;
  assign byte5 = (b5_q | {2'b00, diag_dis_q, 5'h00}) & `DXS_B5_USED;
  assign byte7 = {rej_q, b7_q} & `DXS_B7_USED;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      read_fault <= 1'b0;
    else if (clk_en)
      read_fault <= (~clr & read_fault) |
                    (rd_op & (op_err | (|b5_set)));
  end

  // wishbone slave, ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        `DXS_OFF_WRFLT: wb_dat_o <= {24'h000000, byte4};
        `DXS_OFF_DIAG:  wb_dat_o <= {24'h000000, byte5};
        `DXS_OFF_HEAD:  wb_dat_o <= {24'h000000, b6_q};
        `DXS_OFF_OVR:   wb_dat_o <= {24'h000000, byte7};
        `DXS_OFF_CTRL:  wb_dat_o <= {30'h0, rps_en_q, diag_dis_q};
        `DXS_OFF_SUMM:  wb_dat_o <= {31'h0, read_fault};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  property p_strobe;
    @(posedge clk) disable iff (!nrst)
      clk_en && wr_cmd && strobe_on |=> b4_q[`DXS_B4_STROBE];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe fault");
  property p_offset;
    @(posedge clk) disable iff (!nrst)
      clk_en && wr_cmd && offset_on |=> b4_q[`DXS_B4_OFFSET];
  endproperty
  a_offset: assert property (p_offset) else $error("offset fault");
  sequence s_wait_nodata;
    clk_en && nodata_ev;
  endsequence
  property p_nodata;
    @(posedge clk) disable iff (!nrst)
      s_wait_nodata |=> byte4[`DXS_B4_NODATA];
  endproperty
  a_nodata: assert property (p_nodata) else $error("no data fault");
  property p_wprot;
    @(posedge clk) disable iff (!nrst)
      clk_en && wr_cmd && wprot_on |=> byte4[`DXS_B4_WPROT];
  endproperty
  a_wprot: assert property (p_wprot) else $error("wprot fault");
  property p_heads;
    @(posedge clk) disable iff (!nrst)
      clk_en && head_fail[8] |=> b6_q[7];
  endproperty
  a_heads: assert property (p_heads) else $error("head 8 bit");
  property p_norps;
    @(posedge clk) disable iff (!nrst)
      clk_en && rd_cmd && !rps_en_q && !clr && rej_q == dxs_pkg::DXS_REJ_NONE
      |=> rej_q == dxs_pkg::DXS_REJ_NORPS;
  endproperty
  a_norps: assert property (p_norps) else $error("reject 11");
  property p_unused;
    @(posedge clk) disable iff (!nrst)
      byte4[2:0] == 3'h0 && !byte4[6] && byte5[4:0] == 5'h0 && !byte7[0];
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_sticky;
    @(posedge clk) disable iff (!nrst)
      clk_en && b6_q[0] && !clr |=> b6_q[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("bit lost");
  property p_clear;
    @(posedge clk) disable iff (!nrst)
      clk_en && status_xfer && b6_set == 8'h00 |=> b6_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear lost");
  property p_late;
    @(posedge clk) disable iff (!nrst)
      clk_en && any_cmd && cmd_late |=> b7_q[`DXS_B7_LATE];
  endproperty
  a_late: assert property (p_late) else $error("late bit");
  property p_field;
    @(posedge clk) disable iff (!nrst)
      clk_en && field_pass && op_busy |=> b7_q[`DXS_B7_FIELD];
  endproperty
  a_field: assert property (p_field) else $error("field bit");
  property p_sector;
    @(posedge clk) disable iff (!nrst)
      clk_en && sector_pass && op_busy |=> b7_q[`DXS_B7_SECTOR];
  endproperty
  a_sector: assert property (p_sector) else $error("sector bit");
  property p_track;
    @(posedge clk) disable iff (!nrst)
      clk_en && track_pass && op_busy |=> b7_q[`DXS_B7_TRACK];
  endproperty
  a_track: assert property (p_track) else $error("track bit");
  property p_opflt;
    @(posedge clk) disable iff (!nrst)
      clk_en && op_err |=> b7_q[`DXS_B7_OPFLT];
  endproperty
  a_opflt: assert property (p_opflt) else $error("op fault bit");
  property p_dinc;
    @(posedge clk) disable iff (!nrst)
      clk_en && diag_incomplete |=> byte5[`DXS_B5_INCOMP];
  endproperty
  a_dinc: assert property (p_dinc) else $error("incomplete bit");
  property p_derr;
    @(posedge clk) disable iff (!nrst)
      clk_en && diag_error |=> byte5[`DXS_B5_DVALID];
  endproperty
  a_derr: assert property (p_derr) else $error("diag valid bit");
  property p_ddis;
    @(posedge clk) disable iff (!nrst)
      clk_en && wb_hit && wb_adr_i == `DXS_OFF_DIAG
      |=> wb_dat_o[`DXS_B5_DIAGDIS] == $past(diag_dis_q);
  endproperty
  a_ddis: assert property (p_ddis) else $error("diag dis bit");
  property p_head0;
    @(posedge clk) disable iff (!nrst)
      clk_en && head_fail[0] |=> b6_q[0];
  endproperty
  a_head0: assert property (p_head0) else $error("head 0 bit");
  property p_rejcon;
    @(posedge clk) disable iff (!nrst)
      clk_en && any_cmd && rps_en_q && cmd_conflict && !clr &&
      rej_q == dxs_pkg::DXS_REJ_NONE
      |=> rej_q == dxs_pkg::DXS_REJ_CONFLICT;
  endproperty
  a_rejcon: assert property (p_rejcon) else $error("reject 10");
  property p_rejinv;
    @(posedge clk) disable iff (!nrst)
      clk_en && any_cmd && rps_en_q && !cmd_conflict && cmd_invalid &&
      !clr && rej_q == dxs_pkg::DXS_REJ_NONE
      |=> rej_q == dxs_pkg::DXS_REJ_INVALID;
  endproperty
  a_rejinv: assert property (p_rejinv) else $error("reject 01");
  property p_rfault;
    @(posedge clk) disable iff (!nrst)
      clk_en && rd_op && op_err |=> read_fault;
  endproperty
  a_rfault: assert property (p_rfault) else $error("read fault");
endmodule : dxs_top

// *** dxs_cac_model.sv ***
// controller model: write data commands, then the write data
// assumes go is a one-cycle request from the bench
`timescale 1ns/1ps
module dxs_cac_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic go,
  input  wire logic give,
  output logic      wr_cmd,
  output logic      wr_data_seen
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_cmd <= 1'b0;
    end else begin
      wr_cmd <= go;
    end
  end
  // data after command
  // withheld data lets the drive timeout fire
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q        <= 3'h0;
      wr_data_seen <= 1'b0;
    end else begin
      wr_data_seen <= (cnt_q == 3'h1);
      if (go && give) begin
        cnt_q <= 3'h4;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule : dxs_cac_model

// *** drive_exception_status_bytes_tb_top.sv ***
// bench for the exception status bytes over wishbone
// assumes dxs_top and dxs_cac_model, clk_en tied high
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, s); end end
module drive_exception_status_bytes_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, pin = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, rf, wrc, wds, give = 1'b0;
  logic        rd_op = 1'b0, op_busy = 1'b0, xfer = 1'b0;
  logic [18:0] ev = 19'h0;
  logic [38:0] rows [16];
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #4 clk = ~clk;
  dxs_top DUT (.clk(clk), .nrst(nrst), .clk_en(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wr_cmd(wrc), .rd_cmd(ev[1]), .rd_op(rd_op), .wr_data_seen(wds),
    .cmd_invalid(ev[2]), .cmd_conflict(ev[3]), .cmd_late(ev[4]),
    .diag_incomplete(ev[5]), .diag_error(ev[6]), .field_pass(ev[7]),
    .sector_pass(ev[8]), .track_pass(ev[9]), .op_busy(op_busy),
    .head_fail(ev[18:10]), .strobe_early_pin(pin[3]),
    .strobe_late_pin(pin[2]), .head_offset_pin(pin[1]),
    .wprot_pin(pin[0]), .status_xfer(xfer), .read_fault(rf));
  dxs_cac_model cac (.clk(clk), .nrst(nrst), .go(ev[0]), .give(give),
    .wr_cmd(wrc), .wr_data_seen(wds));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int i = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
                        input string n);
    wb(1'b0, a, 32'h0);
    `CHK(n, {24'h0, e}, q)
  endtask : chk_rd
  task automatic pulse(input logic [18:0] v, input logic x);
    @(posedge clk);
    ev   <= v;
    xfer <= x;
    @(posedge clk);
    ev   <= 19'h0;
    xfer <= 1'b0;
  endtask : pulse
  initial begin
    rows[0]  = {8'h0c, 4'h0, 19'h00080, 8'h12};
    rows[1]  = {8'h0c, 4'h0, 19'h00100, 8'h14};
    rows[2]  = {8'h0c, 4'h0, 19'h00200, 8'h18};
    rows[3]  = {8'h0c, 4'h0, 19'h00012, 8'h30};
    rows[4]  = {8'h0c, 4'h0, 19'h00006, 8'h50};
    rows[5]  = {8'h0c, 4'h0, 19'h0000a, 8'h90};
    rows[6]  = {8'h04, 4'h0, 19'h00020, 8'h40};
    rows[7]  = {8'h04, 4'h0, 19'h00040, 8'h80};
    rows[8]  = {8'h08, 4'h0, 19'h00400, 8'h01};
    rows[9]  = {8'h08, 4'h0, 19'h10000, 8'h40};
    rows[10] = {8'h08, 4'h0, 19'h20000, 8'h80};
    rows[11] = {8'h08, 4'h0, 19'h40000, 8'h80};
    rows[12] = {8'h00, 4'h8, 19'h00001, 8'h08};
    rows[13] = {8'h00, 4'h4, 19'h00001, 8'h08};
    rows[14] = {8'h00, 4'h2, 19'h00001, 8'h10};
    rows[15] = {8'h00, 4'h1, 19'h00001, 8'h80};
    repeat (2) @(posedge clk);
    nrst    <= 1'b1;
    op_busy <= 1'b1;
    give    <= 1'b1;
    for (logic [7:0] a = 8'h0; a < 8'h10; a += 8'h4)
      chk_rd(a, 8'h00, "reset");
    `CHK("rf", 1'b0, rf)
    chk_rd(8'h20, 8'h00, "unmapped");
    chk_rd(8'h10, 8'h02, "ctrlrst");
    wb(1'b1, 8'h00, 32'hff);
    chk_rd(8'h00, 8'h00, "readonly");
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      pin <= rows[i][30:27];
      repeat (4) @(posedge clk);
      pulse(rows[i][26:8], 1'b0);
      repeat (8) @(posedge clk);
      pin <= 4'h0;
      chk_rd(rows[i][38:31], rows[i][7:0], "row");
      pulse(19'h0, 1'b1);
      chk_rd(rows[i][38:31], 8'h00, "cleared");
      $display("row %0d done", i);
    end
    // busy low lets the watchdog leave its data state
    give    <= 1'b0;
    op_busy <= 1'b0;
    pulse(19'h1, 1'b0);
    repeat (60) @(posedge clk);
    chk_rd(8'h00, 8'h00, "wait");
    repeat (80) @(posedge clk);
    chk_rd(8'h00, 8'h20, "nodata");
    $display("no data test done");
    wb(1'b1, 8'h10, 32'h3);
    chk_rd(8'h04, 8'h20, "diagdis");
    chk_rd(8'h10, 8'h03, "ctrl");
    wb(1'b1, 8'h10, 32'h0);
    pulse(19'h2, 1'b0);
    chk_rd(8'h0c, 8'hd0, "norps");
    // sensing back on, so a later invalid reject must not replace 11
    wb(1'b1, 8'h10, 32'h2);
    pulse(19'h6, 1'b0);
    chk_rd(8'h0c, 8'hd0, "keep");
    wb(1'b1, 8'h10, 32'h6);
    chk_rd(8'h0c, 8'h00, "swclear");
    $display("control test done");
    rd_op   <= 1'b1;
    op_busy <= 1'b1;
    pulse(19'h80, 1'b0);
    repeat (2) @(posedge clk);
    `CHK("rf", 1'b1, rf)
    chk_rd(8'h14, 8'h01, "summary");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst  <= 1'b1;
    rd_op <= 1'b0;
    @(posedge clk);
    `CHK("rf", 1'b0, rf)
    chk_rd(8'h0c, 8'h00, "reset2");
    $display("read fault test done");
    finish_test();
  end
endmodule : drive_exception_status_bytes_tb_top
